// ===== pes_pkg.sv
package pes_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the management bus
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_INT_MASK  = 5'h12;
  localparam logic [4:0]  ADDR_INT_STAT  = 5'h13;
  localparam logic [4:0]  ADDR_DG_CTRL   = 5'h14;
  localparam logic [4:0]  ADDR_RXERR_CNT = 5'h15;

  // ----------------------------------------------------------------
  // Event status bit positions
  // ----------------------------------------------------------------
  localparam int ST_AN_ERR = 15;
  localparam int ST_SPD    = 14;
  localparam int ST_DUP    = 13;
  localparam int ST_PAGE   = 12;
  localparam int ST_LDN    = 11;
  localparam int ST_LUP    = 10;
  localparam int ST_WOL    = 6;
  localparam int ST_DG     = 5;
  localparam int ST_POL    = 1;
  localparam int ST_JAB    = 0;
  localparam logic [15:0] STAT_IMPL_MASK = 16'hFC63;
  localparam logic [15:0] MASK_RST       = 16'h0000;

  // ----------------------------------------------------------------
  // Downgrade control fields and reset values
  // ----------------------------------------------------------------
  localparam int CT_LATCH     = 11;
  localparam int CT_DG_EN     = 5;
  localparam int CT_RETRY_LSB = 2;
  localparam int CT_BYPASS    = 1;
  localparam logic       LATCH_RST     = 1'b1;
  localparam logic       DG_EN_RST     = 1'b1;
  localparam logic [2:0] RETRY_RST     = 3'h3;
  localparam logic       BYPASS_RST    = 1'b0;
  localparam logic [3:0] ATTEMPT_EXTRA = 4'h2;

  // ----------------------------------------------------------------
  // Speed codes and counter limits
  // ----------------------------------------------------------------
  localparam logic [1:0]  SPEED_10   = 2'h0;
  localparam logic [1:0]  SPEED_100  = 2'h1;
  localparam logic [15:0] RXERR_MAX  = 16'hFFFF;

  // ----------------------------------------------------------------
  // Management frame fields
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_ONES  = 6'h20;
  localparam logic [4:0] HDR_LAST  = 5'h0D;
  localparam logic [1:0] ST_CODE   = 2'h1;
  localparam logic [1:0] OP_RD     = 2'h2;
  localparam logic [1:0] OP_WR     = 2'h1;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 50000000;
  localparam int STAB_TIME_MS    = 2500;
  localparam int STAB_CYCLES_DEF = STAB_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic an_err;
    logic page_rx;
    logic wol;
    logic pol_rev;
    logic jabber;
  } pes_ev_s;

  typedef struct packed {
    logic       latch;
    logic       dg_en;
    logic [2:0] retry;
    logic       bypass;
  } pes_ctrl_s;

  typedef enum logic [4:0] {
    MS_PRE = 5'b00001,
    MS_HDR = 5'b00010,
    MS_TA  = 5'b00100,
    MS_RD  = 5'b01000,
    MS_WR  = 5'b10000
  } pes_mdio_e;

endpackage : pes_pkg

// ===== pes_phy_event_status.sv
// Operation
// - Mask bit one lets event raise request
// - Bit 15 flags auto-negotiation error
// - Bit 14 flags speed change until read
// - Bit 13 flags duplex change until read
// - Bit 12 flags received negotiation page
// - Bit 11 flags link down until read
// - Bit 10 flags link up until read
// - Bit 6 flags wake magic frame
// - Bit 5 flags automatic speed downgrade
// - Bit 1 flags receive polarity reversal
// - Bit 0 flags 10M transmit jabber
// - Latch bit freezes read value per frame
// - Downgrade enable takes effect after soft reset
// - Attempts before downgrade equal limit plus two
// - Short-lived link counts failed unless bypassed
// - Count each receive error burst that starts while rx_dv_i is high once
// - Error counter saturates, never wraps
// - Error counter counts only at 100M
`timescale 1ns/1ps
module pes_phy_event_status #(
  parameter int STAB_CYCLES = pes_pkg::STAB_CYCLES_DEF
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             soft_rst_i,
  input  wire logic [4:0]       phy_addr_i,
  input  wire logic             mdc_i,
  input  wire logic             mdio_i,
  output logic                  mdio_o,
  output logic                  mdio_oe_o,
  input  wire pes_pkg::pes_ev_s ev_i,
  input  wire logic [1:0]       speed_i,
  input  wire logic             duplex_i,
  input  wire logic             link_i,
  input  wire logic             an_fail_i,
  input  wire logic             rx_er_i,
  input  wire logic             rx_dv_i,
  output logic                  int_o,
  output logic                  dg_en_o,
  output logic                  downgrade_o
);

  generate
    if (STAB_CYCLES < 2) begin : g_chk
      $error("STAB_CYCLES must be at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic       mdc_s1, mdc_s2, mdc_s3;
  logic       mdio_s1, mdio_s2;
  logic [4:0] addr_s1, addr_s2;
  logic       mdc_rise;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mdc_s1  <= 1'b0;
      mdc_s2  <= 1'b0;
      mdc_s3  <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      addr_s1 <= 5'h00;
      addr_s2 <= 5'h00;
    end else begin
      mdc_s1  <= mdc_i;
      mdc_s2  <= mdc_s1;
      mdc_s3  <= mdc_s2;
      mdio_s1 <= mdio_i;
      mdio_s2 <= mdio_s1;
      addr_s1 <= phy_addr_i;
      addr_s2 <= addr_s1;
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_s3;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0]        mask_r, stat_r, stat_nxt, stat_snap_r, set_vec, rxerr_r;
  pes_pkg::pes_ctrl_s ctrl_r;
  logic               dg_en_act_r;
  logic [1:0]         speed_d_r;
  logic               duplex_d_r, link_d_r, rx_er_d_r, rx_start;
  logic               dg_pulse_r, int_r;

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  pes_pkg::pes_mdio_e state_r;
  logic [5:0]         ones_r;
  logic [13:0]        hdr_r, hdr_nxt;
  logic [4:0]         cnt_r, sel_addr;
  logic [15:0]        rd_sh_r, wr_sh_r, live_rdata, rd_src;
  logic               rd_latch_r, rd_done_r, wr_stb_r, mdio_o_r, mdio_oe_r;
  logic               frame_ok, is_rd;

  function automatic logic pick_bit(input logic [15:0] w, input logic [3:0] i);
    return w[i];
  endfunction : pick_bit

  assign hdr_nxt  = {hdr_r[12:0], mdio_s2};
  assign sel_addr = (state_r == pes_pkg::MS_HDR) ? hdr_nxt[4:0] : hdr_r[4:0];
  assign frame_ok = (hdr_nxt[13:12] == pes_pkg::ST_CODE) && (hdr_nxt[9:5] == addr_s2) &&
                    ((hdr_nxt[11:10] == pes_pkg::OP_RD) || (hdr_nxt[11:10] == pes_pkg::OP_WR));
  assign is_rd    = (hdr_r[11:10] == pes_pkg::OP_RD);
  assign rd_src   = rd_latch_r ? rd_sh_r : live_rdata;

  always_comb begin
    unique case (sel_addr)
      pes_pkg::ADDR_INT_MASK:  live_rdata = mask_r;
      pes_pkg::ADDR_INT_STAT:  live_rdata = stat_r;
      pes_pkg::ADDR_DG_CTRL:   live_rdata = {4'h0, ctrl_r.latch, 5'h00, ctrl_r.dg_en,
                                             ctrl_r.retry, ctrl_r.bypass, 1'b0};
      pes_pkg::ADDR_RXERR_CNT: live_rdata = rxerr_r;
      default:                 live_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r     <= pes_pkg::MS_PRE;
      ones_r      <= 6'h00;
      hdr_r       <= 14'h0000;
      cnt_r       <= 5'h00;
      rd_sh_r     <= 16'h0000;
      wr_sh_r     <= 16'h0000;
      rd_latch_r  <= 1'b0;
      rd_done_r   <= 1'b0;
      wr_stb_r    <= 1'b0;
      mdio_o_r    <= 1'b0;
      mdio_oe_r   <= 1'b0;
      stat_snap_r <= 16'h0000;
    end else begin
      rd_done_r <= 1'b0;
      wr_stb_r  <= 1'b0;
      if (mdc_rise) begin
        unique case (state_r)
          pes_pkg::MS_PRE: begin
            if (mdio_s2) begin
              ones_r <= (ones_r == pes_pkg::PRE_ONES) ? ones_r : ones_r + 6'h01;
            end else begin
              ones_r <= 6'h00;
              if (ones_r == pes_pkg::PRE_ONES) begin
                state_r <= pes_pkg::MS_HDR;
                hdr_r   <= 14'h0000;
                cnt_r   <= 5'h01;
              end
            end
          end
          pes_pkg::MS_HDR: begin
            hdr_r <= hdr_nxt;
            if (cnt_r == pes_pkg::HDR_LAST) begin
              cnt_r <= 5'h00;
              if (frame_ok) begin
                state_r <= pes_pkg::MS_TA;
                // Freeze the word at the start of the read
                rd_sh_r     <= live_rdata;
                rd_latch_r  <= ctrl_r.latch;
                stat_snap_r <= stat_r;
              end else begin
                state_r <= pes_pkg::MS_PRE;
              end
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
          pes_pkg::MS_TA: begin
            if (cnt_r == 5'h00) begin
              cnt_r     <= 5'h01;
              mdio_oe_r <= is_rd;
              mdio_o_r  <= 1'b0;
            end else begin
              cnt_r <= pes_pkg::DATA_LAST;
              if (is_rd) begin
                mdio_o_r <= pick_bit(rd_src, 4'hF);
                state_r  <= pes_pkg::MS_RD;
              end else begin
                state_r <= pes_pkg::MS_WR;
              end
            end
          end
          pes_pkg::MS_RD: begin
            if (cnt_r == 5'h00) begin
              mdio_oe_r <= 1'b0;
              mdio_o_r  <= 1'b0;
              rd_done_r <= 1'b1;
              state_r   <= pes_pkg::MS_PRE;
            end else begin
              cnt_r    <= cnt_r - 5'h01;
              mdio_o_r <= pick_bit(rd_src, cnt_r[3:0] - 4'h1);
            end
          end
          pes_pkg::MS_WR: begin
            wr_sh_r <= {wr_sh_r[14:0], mdio_s2};
            if (cnt_r == 5'h00) begin
              wr_stb_r <= 1'b1;
              state_r  <= pes_pkg::MS_PRE;
            end else begin
              cnt_r <= cnt_r - 5'h01;
            end
          end
        endcase
      end
    end
  end

  assign mdio_o    = mdio_o_r;
  assign mdio_oe_o = mdio_oe_r;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mask_r       <= pes_pkg::MASK_RST;
      ctrl_r       <= '{latch: pes_pkg::LATCH_RST, dg_en: pes_pkg::DG_EN_RST,
                        retry: pes_pkg::RETRY_RST, bypass: pes_pkg::BYPASS_RST};
      dg_en_act_r  <= pes_pkg::DG_EN_RST;
    end else begin
      if (wr_stb_r && (hdr_r[4:0] == pes_pkg::ADDR_INT_MASK)) begin
        mask_r <= wr_sh_r & pes_pkg::STAT_IMPL_MASK;
      end
      if (wr_stb_r && (hdr_r[4:0] == pes_pkg::ADDR_DG_CTRL)) begin
        ctrl_r.latch  <= wr_sh_r[pes_pkg::CT_LATCH];
        ctrl_r.dg_en  <= wr_sh_r[pes_pkg::CT_DG_EN];
        ctrl_r.retry  <= wr_sh_r[pes_pkg::CT_RETRY_LSB +: 3];
        ctrl_r.bypass <= wr_sh_r[pes_pkg::CT_BYPASS];
      end
      if (soft_rst_i) begin
        dg_en_act_r <= ctrl_r.dg_en;
      end
    end
  end

  assign dg_en_o = dg_en_act_r;

  // ----------------------------------------------------------------
  // Event status, clear on read
  // ----------------------------------------------------------------
  always_comb begin
    set_vec                   = 16'h0000;
    set_vec[pes_pkg::ST_AN_ERR] = ev_i.an_err;
    set_vec[pes_pkg::ST_SPD]  = (speed_i != speed_d_r);
    set_vec[pes_pkg::ST_DUP]  = (duplex_i != duplex_d_r);
    set_vec[pes_pkg::ST_PAGE] = ev_i.page_rx;
    set_vec[pes_pkg::ST_LDN]  = ~link_i & link_d_r;
    set_vec[pes_pkg::ST_LUP]  = link_i & ~link_d_r;
    set_vec[pes_pkg::ST_WOL]  = ev_i.wol;
    set_vec[pes_pkg::ST_DG]   = dg_pulse_r;
    set_vec[pes_pkg::ST_POL]  = ev_i.pol_rev;
    set_vec[pes_pkg::ST_JAB]  = ev_i.jabber & (speed_i == pes_pkg::SPEED_10);
    stat_nxt = stat_r;
    if (rd_done_r && (hdr_r[4:0] == pes_pkg::ADDR_INT_STAT)) begin
      stat_nxt = stat_r & ~stat_snap_r;
    end
    stat_nxt = (stat_nxt | set_vec) & pes_pkg::STAT_IMPL_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stat_r     <= 16'h0000;
      speed_d_r  <= pes_pkg::SPEED_10;
      duplex_d_r <= 1'b0;
      link_d_r   <= 1'b0;
      int_r      <= 1'b0;
    end else begin
      stat_r     <= soft_rst_i ? 16'h0000 : stat_nxt;
      speed_d_r  <= speed_i;
      duplex_d_r <= duplex_i;
      link_d_r   <= link_i;
      int_r      <= |(stat_r & mask_r);
    end
  end

  assign int_o = int_r;

  // ----------------------------------------------------------------
  // Speed downgrade retry logic
  // ----------------------------------------------------------------
  logic [31:0] tmr_r;
  logic        tmr_run_r, attempt_fail;
  logic [3:0]  attempts_r, limit;

  assign limit        = {1'b0, ctrl_r.retry} + pes_pkg::ATTEMPT_EXTRA;
  assign attempt_fail = an_fail_i | (tmr_run_r & ~link_i & ~ctrl_r.bypass);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tmr_r      <= 32'h0000_0000;
      tmr_run_r  <= 1'b0;
      attempts_r <= 4'h0;
      dg_pulse_r <= 1'b0;
    end else if (soft_rst_i) begin
      tmr_r      <= 32'h0000_0000;
      tmr_run_r  <= 1'b0;
      attempts_r <= 4'h0;
      dg_pulse_r <= 1'b0;
    end else begin
      dg_pulse_r <= 1'b0;
      if (link_i && !link_d_r) begin
        tmr_r     <= 32'h0000_0000;
        tmr_run_r <= ~ctrl_r.bypass;
        if (ctrl_r.bypass) begin
          attempts_r <= 4'h0;
        end
      end else if (tmr_run_r && link_i) begin
        tmr_r <= tmr_r + 32'h0000_0001;
        if (tmr_r == 32'(STAB_CYCLES - 1)) begin
          tmr_run_r  <= 1'b0;
          attempts_r <= 4'h0;
        end
      end else if (!link_i) begin
        tmr_run_r <= 1'b0;
      end
      if (attempt_fail) begin
        if (attempts_r + 4'h1 >= limit) begin
          attempts_r <= 4'h0;
          dg_pulse_r <= dg_en_act_r & (speed_i != pes_pkg::SPEED_10);
        end else begin
          attempts_r <= attempts_r + 4'h1;
        end
      end
    end
  end

  assign downgrade_o = dg_pulse_r;

  // ----------------------------------------------------------------
  // Receive error counter
  // ----------------------------------------------------------------
  assign rx_start = rx_er_i & ~rx_er_d_r & rx_dv_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_er_d_r <= 1'b0;
      rxerr_r   <= 16'h0000;
    end else begin
      rx_er_d_r <= rx_er_i;
      if (soft_rst_i || (speed_i != pes_pkg::SPEED_100)) begin
        rxerr_r <= 16'h0000;
      end else if (rx_start && (rxerr_r != pes_pkg::RXERR_MAX)) begin
        rxerr_r <= rxerr_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_int_mask;
    @(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> (int_o == $past(|(stat_r & mask_r)));
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("request does not follow masked status");

  property p_an_err;
    @(posedge clk_i) disable iff (!rst_b_i)
    (ev_i.an_err && !soft_rst_i) |=> stat_r[pes_pkg::ST_AN_ERR];
  endproperty
  a_an_err: assert property (p_an_err) else $error("negotiation error not flagged");

  property p_spd_chg;
    @(posedge clk_i) disable iff (!rst_b_i)
    ($changed(speed_i) && !$past(soft_rst_i) && !soft_rst_i) ##1 !soft_rst_i |-> stat_r[pes_pkg::ST_SPD];
  endproperty
  a_spd_chg: assert property (p_spd_chg) else $error("speed change not flagged");

  property p_link_dn;
    @(posedge clk_i) disable iff (!rst_b_i)
    (!link_i && link_d_r && !soft_rst_i) |=> stat_r[pes_pkg::ST_LDN];
  endproperty
  a_link_dn: assert property (p_link_dn) else $error("link down not flagged");

  property p_link_up;
    @(posedge clk_i) disable iff (!rst_b_i)
    (link_i && !link_d_r && !soft_rst_i) |=> stat_r[pes_pkg::ST_LUP];
  endproperty
  a_link_up: assert property (p_link_up) else $error("link up not flagged");

  property p_set_wins;
    @(posedge clk_i) disable iff (!rst_b_i)
    !soft_rst_i |=> ((stat_r & $past(set_vec)) == $past(set_vec & pes_pkg::STAT_IMPL_MASK));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clearing read");

  property p_rx_inc;
    @(posedge clk_i) disable iff (!rst_b_i)
    (rx_start && !soft_rst_i && (speed_i == pes_pkg::SPEED_100) && (rxerr_r != pes_pkg::RXERR_MAX))
      |=> (rxerr_r == $past(rxerr_r) + 16'h0001);
  endproperty
  a_rx_inc: assert property (p_rx_inc) else $error("error burst not counted");

  property p_rx_sat;
    @(posedge clk_i) disable iff (!rst_b_i)
    ((rxerr_r == pes_pkg::RXERR_MAX) && !soft_rst_i && (speed_i == pes_pkg::SPEED_100))
      |=> (rxerr_r == pes_pkg::RXERR_MAX);
  endproperty
  a_rx_sat: assert property (p_rx_sat) else $error("error counter wrapped");

  property p_rx_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
    (speed_i != pes_pkg::SPEED_100) |=> (rxerr_r == 16'h0000);
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("error counter nonzero off 100M");

  property p_rsvd;
    @(posedge clk_i) disable iff (!rst_b_i)
    ((stat_r | mask_r) & ~pes_pkg::STAT_IMPL_MASK) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");

  property p_dg_en;
    @(posedge clk_i) disable iff (!rst_b_i)
    !soft_rst_i |=> (dg_en_o == $past(dg_en_o));
  endproperty
  a_dg_en: assert property (p_dg_en) else $error("downgrade enable moved without soft reset");

endmodule : pes_phy_event_status

// ===== pes_mdio_station.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Station manager driving management frames
// ----------------------------------------------------------------
module pes_mdio_station #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  initial begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b0;
    mdio_oe_o = 1'b0;
  end

  // One clock period: data changes while low, line sampled just before the rise
  task automatic tick(input logic en, input logic d, output logic s);
    mdc_o     = 1'b0;
    mdio_oe_o = en;
    mdio_o    = d;
    #80;
    s     = mdio_i;
    mdc_o = 1'b1;
    #80;
  endtask : tick

  // Whole frame; the clock stands still low between frames
  task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hFFFF_FFFF, pes_pkg::ST_CODE, (wr ? pes_pkg::OP_WR : pes_pkg::OP_RD), PHY_ADDR, ra};
    for (int i = 45; i >= 0; i--) begin
      tick(1'b1, hdr[i], s);
    end
    tick(wr, 1'b1, s);
    tick(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      tick(wr, wd[i], s);
      rd[i] = s;
    end
    mdc_o     = 1'b0;
    mdio_oe_o = 1'b0;
    mdio_o    = 1'b1;
    #400;
  endtask : xfer
endmodule : pes_mdio_station

// ===== phy_event_status_regs_bench.sv
`timescale 1ns/1ps
module phy_event_status_regs_bench;
  typedef struct packed {
    logic [3:0]  kind;
    logic [15:0] exp;
  } pes_row_s;

  logic             clk_i;
  logic             rst_b_i;
  logic             soft_rst_i;
  logic [1:0]       speed_i;
  logic             duplex_i;
  logic             link_i;
  logic             an_fail_i;
  logic             rx_er_i;
  logic             rx_dv_i;
  pes_pkg::pes_ev_s ev_i;
  wire logic        mdc;
  wire logic        mdio_line;
  logic             mdio_o;
  logic             mdio_oe_o;
  logic             st_o;
  logic             st_oe;
  logic             int_o;
  logic             dg_en_o;
  logic             downgrade_o;
  logic [15:0]      rd;
  int               error_cnt;
  int               samples_checked;
  int               cycles;
  int               dg_cnt;
  pes_row_s         rows [9] = '{'{4'h0, 16'h0001}, '{4'h1, 16'h0002}, '{4'h2, 16'h0040},
                                 '{4'h3, 16'h1000}, '{4'h4, 16'h8000}, '{4'h5, 16'h2000},
                                 '{4'h6, 16'h4000}, '{4'h7, 16'h0400}, '{4'h8, 16'h0800}};

  // Pull-up when nobody drives the management data line
  assign mdio_line = mdio_oe_o ? mdio_o : (st_oe ? st_o : 1'b1);

  pes_phy_event_status #(.STAB_CYCLES(50)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i), .phy_addr_i(5'h01),
    .mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .ev_i(ev_i),
    .speed_i(speed_i), .duplex_i(duplex_i), .link_i(link_i), .an_fail_i(an_fail_i),
    .rx_er_i(rx_er_i), .rx_dv_i(rx_dv_i), .int_o(int_o), .dg_en_o(dg_en_o), .downgrade_o(downgrade_o)
  );

  pes_mdio_station #(.PHY_ADDR(5'h01)) st_u (
    .mdio_i(mdio_line), .mdc_o(mdc), .mdio_o(st_o), .mdio_oe_o(st_oe)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and downgrade pulse counting
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever begin
      #10 clk_i = ~clk_i;
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (downgrade_o === 1'b1) begin
      dg_cnt++;
    end
    if (cycles >= 80000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string nm);
    st_u.xfer(1'b0, a, 16'h0000, rd);
    chk(nm, e, rd);
  endtask : rd_chk

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    st_u.xfer(1'b1, a, d, rd);
  endtask : wr_reg

  task automatic pulse_soft;
    @(negedge clk_i);
    soft_rst_i = 1'b1;
    @(negedge clk_i);
    soft_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    dg_cnt = 0;
  endtask : pulse_soft

  task automatic fail_attempt;
    @(negedge clk_i);
    an_fail_i = 1'b1;
    @(negedge clk_i);
    an_fail_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : fail_attempt

  task automatic short_link;
    @(negedge clk_i);
    link_i = 1'b1;
    repeat (10) @(negedge clk_i);
    link_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : short_link

  // One error burst a fixed number of cycles into a running frame
  task automatic burst_at(input int n);
    repeat (n) @(negedge clk_i);
    rx_er_i = 1'b1;
    @(negedge clk_i);
    rx_er_i = 1'b0;
  endtask : burst_at

  task automatic apply(input logic [3:0] k);
    @(negedge clk_i);
    case (k)
      4'h0: ev_i.jabber = 1'b1;
      4'h1: ev_i.pol_rev = 1'b1;
      4'h2: ev_i.wol = 1'b1;
      4'h3: ev_i.page_rx = 1'b1;
      4'h4: ev_i.an_err = 1'b1;
      4'h5: duplex_i = 1'b1;
      4'h6: speed_i = pes_pkg::SPEED_100;
      4'h7: link_i = 1'b1;
      4'h8: link_i = 1'b0;
      default: ;
    endcase
    @(negedge clk_i);
    ev_i = '0;
    repeat (3) @(negedge clk_i);
  endtask : apply

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b_i, soft_rst_i, duplex_i, link_i, an_fail_i, rx_er_i, rx_dv_i} = '0;
    speed_i = pes_pkg::SPEED_10;
    ev_i    = '0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("dg_en", 16'h0001, {15'h0, dg_en_o});
    chk("int", 16'h0000, {15'h0, int_o});
    rd_chk(pes_pkg::ADDR_INT_MASK, 16'h0000, "mask reset");
    rd_chk(pes_pkg::ADDR_INT_STAT, 16'h0000, "status reset");
    rd_chk(pes_pkg::ADDR_DG_CTRL, 16'h082C, "ctrl reset");
    rd_chk(pes_pkg::ADDR_RXERR_CNT, 16'h0000, "count reset");
    wr_reg(pes_pkg::ADDR_DG_CTRL, 16'hFFFF);
    rd_chk(pes_pkg::ADDR_DG_CTRL, 16'h083E, "ctrl reserved");
    wr_reg(pes_pkg::ADDR_DG_CTRL, 16'h082C);
    rd_chk(5'h1A, 16'h0000, "unmapped");
    wr_reg(pes_pkg::ADDR_INT_MASK, 16'hFC63);
    foreach (rows[i]) begin
      apply(rows[i].kind);
      chk("int set", 16'h0001, {15'h0, int_o});
      rd_chk(pes_pkg::ADDR_INT_STAT, rows[i].exp, "status");
      rd_chk(pes_pkg::ADDR_INT_STAT, 16'h0000, "status clear");
      chk("int clear", 16'h0000, {15'h0, int_o});
    end
    wr_reg(pes_pkg::ADDR_INT_MASK, 16'h0000);
    apply(4'h2);
    chk("int masked", 16'h0000, {15'h0, int_o});
    rd_chk(pes_pkg::ADDR_INT_STAT, 16'h0040, "masked status");
    pulse_soft();
    repeat (4) fail_attempt();
    chk("no downgrade", 16'h0000, dg_cnt[15:0]);
    fail_attempt();
    chk("downgrade", 16'h0001, dg_cnt[15:0]);
    rd_chk(pes_pkg::ADDR_INT_STAT, 16'h0020, "dg status");
    wr_reg(pes_pkg::ADDR_DG_CTRL, 16'h0820);
    pulse_soft();
    fail_attempt();
    short_link();
    chk("short link", 16'h0001, dg_cnt[15:0]);
    wr_reg(pes_pkg::ADDR_DG_CTRL, 16'h0822);
    pulse_soft();
    short_link();
    fail_attempt();
    chk("bypass", 16'h0000, dg_cnt[15:0]);
    wr_reg(pes_pkg::ADDR_DG_CTRL, 16'h0802);
    chk("dg_en held", 16'h0001, {15'h0, dg_en_o});
    pulse_soft();
    chk("dg_en loaded", 16'h0000, {15'h0, dg_en_o});
    repeat (2) fail_attempt();
    chk("dg disabled", 16'h0000, dg_cnt[15:0]);
    @(negedge clk_i);
    rx_er_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rx_er_i = 1'b0;
    rx_dv_i = 1'b1;
    repeat (2) begin
      @(negedge clk_i);
      rx_er_i = 1'b1;
      repeat (3) @(negedge clk_i);
      rx_er_i = 1'b0;
      @(negedge clk_i);
    end
    rd_chk(pes_pkg::ADDR_RXERR_CNT, 16'h0002, "rx errors");
    speed_i = pes_pkg::SPEED_10;
    repeat (3) @(negedge clk_i);
    rd_chk(pes_pkg::ADDR_RXERR_CNT, 16'h0000, "rx at 10M");
    speed_i = pes_pkg::SPEED_100;
    repeat (3) @(negedge clk_i);
    // Count moves in mid-frame: latched read keeps 0, live read shows 2
    fork
      rd_chk(pes_pkg::ADDR_RXERR_CNT, 16'h0000, "latched count");
      burst_at(450);
    join
    wr_reg(pes_pkg::ADDR_DG_CTRL, 16'h0002);
    fork
      rd_chk(pes_pkg::ADDR_RXERR_CNT, 16'h0002, "live count");
      burst_at(450);
    join
    stop_test();
  end
endmodule : phy_event_status_regs_bench
